// >>> src/spcu_pkg.sv
package spcu_pkg;
  // command word field positions
  localparam int unsigned STAT_LSB      = 0;
  localparam int unsigned STAT_W        = 4;
  localparam int unsigned DONE_BIT      = 7;
  localparam int unsigned CODE_LSB      = 8;
  localparam int unsigned CODE_W        = 4;
  localparam int unsigned EXEC_BIT      = 15;
  // parameter area geometry
  localparam int unsigned NUM_PARAMS    = 30;
  localparam int unsigned IDX_W         = 5;
  localparam logic [4:0]  GEN_FIRST     = 5'h00;
  localparam logic [4:0]  GEN_LAST      = 5'h05;
  localparam logic [4:0]  CNT_FIRST     = 5'h05;
  localparam logic [4:0]  CNT_LAST      = 5'h13;
  localparam logic [4:0]  SER_FIRST     = 5'h14;
  localparam logic [4:0]  SER_LAST      = 5'h1d;
  // reset, default and limit values
  localparam logic [15:0] CMD_WORD_RST  = 16'h0000;
  localparam logic [15:0] PARAM_DEFAULT = 16'h0000;
  localparam logic [15:0] PARAM_LIMIT   = 16'h9999;

  // command codes
  typedef enum logic [3:0] {
    SPCU_CMD_PSET   = 4'h1,
    SPCU_CMD_BACKUP = 4'h2,
    SPCU_CMD_BKDIS  = 4'h3,
    SPCU_CMD_CLEAR  = 4'h4,
    SPCU_CMD_GSET   = 4'h5,
    SPCU_CMD_CSET   = 4'h6,
    SPCU_CMD_SSET   = 4'h7
  } spcu_cmd_e;

  // response codes
  typedef enum logic [3:0] {
    SPCU_RSP_OK     = 4'h0,
    SPCU_RSP_UNDEF  = 4'h1,
    SPCU_RSP_WPROT  = 4'h2,
    SPCU_RSP_NOSUM  = 4'h3
  } spcu_rsp_e;

  // sequencer states
  typedef enum logic [2:0] {
    SPCU_IDLE    = 3'b000,
    SPCU_DECODE  = 3'b001,
    SPCU_WALK    = 3'b010,
    SPCU_FINISH  = 3'b011
  } spcu_state_e;
endpackage : spcu_pkg

// >>> src/spcu_checksum.sv
`timescale 1ns/1ps
`default_nettype none
// running checksum over a stream of words
module spcu_checksum #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             i_clk_sys, // system clock
  input  wire logic             i_rst_n,   // async reset, active low
  input  wire logic             i_clear,   // restart the sum
  input  wire logic             i_add,     // accumulate one word
  input  wire logic [WIDTH-1:0] i_word,    // word to add
  output logic      [WIDTH-1:0] o_sum      // current sum
);
  logic [WIDTH-1:0] sum_ff;
  logic [WIDTH-1:0] nxt_sum;

  // modular add with rotate so word order matters
  always_comb begin
    nxt_sum = sum_ff;
    if (i_clear) begin
      nxt_sum = '0;
    end else if (i_add) begin
      nxt_sum = {sum_ff[WIDTH-2:0], sum_ff[WIDTH-1]} + i_word;
    end
  end

  // register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum_ff <= '0;
    end else begin
      sum_ff <= nxt_sum;
    end
  end

  assign o_sum = sum_ff;
endmodule : spcu_checksum
`default_nettype wire

// >>> src/spcu_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - write completion status into bits 0-3
// - status 0 on success
// - status 1 on undefined command code
// - status 2 when memory write-protected
// - status 3 when no parameter checksum
// - set completion bit 7 on any end
// - ignore codes from non-peripheral writes
// - code 1 loads, checks, defaults, sums
// - code 2 backs up, sums, sets flag
// - code 3 disables backup, clears flag
// - code 4 zeros all parameter words
// - codes 5-7 act on word subsets
// - start on peripheral code change with force
// - no execute unless peripheral force-set
// - execute bit self-clears unless forced
// - word bits 0-11 updated only on command execution
// - success reads 8, code, 80
// - keep backup flag; refresh sum error on force-set
module spcu_unit #(
  parameter int unsigned NWORDS = spcu_pkg::NUM_PARAMS
) (
  input  wire logic        i_clk_sys,      // system clock
  input  wire logic        i_rst_n,        // async reset, active low
  input  wire logic        i_periph_wr,    // peripheral hex/bcd or binary data change strobe
  input  wire logic        i_prog_wr,      // user program write strobe
  input  wire logic [15:0] i_wr_data,      // data written to the command word
  input  wire logic        i_force_exec,   // peripheral force-set of execute bit (level)
  input  wire logic        i_mem_wprot,    // memory unit write-protected or eprom
  input  wire logic        i_par_we,       // parameter area write strobe
  input  wire logic [4:0]  i_par_addr,     // parameter area word index
  input  wire logic [15:0] i_par_wdata,    // parameter area write data
  output logic      [15:0] o_cmd_word,     // command word
  output logic             o_backup_flag,  // backup valid flag
  output logic             o_sum_err,      // parameter/backup checksum mismatch
  output logic [29:0]      o_warn,         // per-word invalid value warnings
  output logic             o_busy          // command in progress
);
  import spcu_pkg::*;

  // parameter area, backup area and active copy
  logic [15:0]      par_ff    [NWORDS];
  logic [15:0]      bak_ff    [NWORDS];
  logic [15:0]      act_ff    [NWORDS];
  logic [15:0]      nxt_par   [NWORDS];
  logic [15:0]      nxt_bak   [NWORDS];
  logic [15:0]      nxt_act   [NWORDS];

  spcu_state_e      state_ff, nxt_state;
  logic [15:0]      cmd_ff, nxt_cmd;
  logic [3:0]       op_ff, nxt_op;
  logic [3:0]       rsp_ff, nxt_rsp;
  logic [4:0]       idx_ff, nxt_idx;
  logic [4:0]       last_ff, nxt_last;
  logic             bak_flag_ff, nxt_bak_flag;
  logic             sum_valid_ff, nxt_sum_valid;
  logic             sum_err_ff, nxt_sum_err;
  logic [29:0]      warn_ff, nxt_warn;
  logic [15:0]      par_sum_ff, nxt_par_sum;
  logic [15:0]      bak_sum_ff, nxt_bak_sum;
  logic             force_d_ff;
  logic             busy_ff;

  logic             sum_clear;
  logic             sum_add;
  logic [15:0]      sum_word;
  logic [15:0]      sum_out;
  logic [15:0]      cur_word;
  logic             cur_bad;
  logic             code_wr;

  // checksum engine shared by set and backup walks
  spcu_checksum #(
    .WIDTH (16)
  ) u_sum (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_clear   (sum_clear),
    .i_add     (sum_add),
    .i_word    (sum_word),
    .o_sum     (sum_out)
  );

  // only a peripheral data change with force held can launch
  assign code_wr  = i_periph_wr && i_force_exec && !i_prog_wr;
  assign cur_word = par_ff[idx_ff];
  // a word is invalid when a nibble is not bcd
  assign cur_bad  = (cur_word[3:0] > 4'h9) || (cur_word[7:4] > 4'h9) ||
                    (cur_word[11:8] > 4'h9) || (cur_word[15:12] > 4'h9) ||
                    (cur_word > PARAM_LIMIT);
  assign sum_clear = (state_ff == SPCU_DECODE);
  assign sum_add   = (state_ff == SPCU_WALK) &&
                     (op_ff != 4'(SPCU_CMD_CLEAR));
  assign sum_word  = cur_bad ? PARAM_DEFAULT : cur_word;

  // command sequencer next state
  always_comb begin
    nxt_state     = state_ff;
    nxt_cmd       = cmd_ff;
    nxt_op        = op_ff;
    nxt_rsp       = rsp_ff;
    nxt_idx       = idx_ff;
    nxt_last      = last_ff;
    nxt_bak_flag  = bak_flag_ff;
    nxt_sum_valid = sum_valid_ff;
    nxt_sum_err   = sum_err_ff;
    nxt_warn      = warn_ff;
    nxt_par_sum   = par_sum_ff;
    nxt_bak_sum   = bak_sum_ff;
    for (int k = 0; k < NWORDS; k++) begin
      nxt_par[k] = par_ff[k];
      nxt_bak[k] = bak_ff[k];
      nxt_act[k] = act_ff[k];
    end
    // ordinary parameter area writes when idle
    if (i_par_we && (state_ff == SPCU_IDLE) && (i_par_addr < 5'(NWORDS))) begin
      nxt_par[i_par_addr] = i_par_wdata;
    end
    // sum error flag refreshed when execute becomes forced
    if (i_force_exec && !force_d_ff) begin
      nxt_sum_err = bak_flag_ff && sum_valid_ff && (par_sum_ff != bak_sum_ff);
    end
    // execute bit self-clears once force is released
    if (!i_force_exec && (state_ff == SPCU_IDLE)) begin
      nxt_cmd[EXEC_BIT] = 1'b0;
    end
    case (state_ff)
      SPCU_IDLE: begin
        if (code_wr) begin
          nxt_op    = i_wr_data[CODE_LSB +: CODE_W];
          nxt_cmd   = {1'b1, 3'b000, i_wr_data[CODE_LSB +: CODE_W], 8'h00};
          nxt_state = SPCU_DECODE;
        end
      end
      SPCU_DECODE: begin
        nxt_state = SPCU_WALK;
        nxt_rsp   = 4'(SPCU_RSP_OK);
        case (op_ff)
          4'(SPCU_CMD_PSET), 4'(SPCU_CMD_CLEAR): begin
            nxt_idx  = GEN_FIRST;
            nxt_last = SER_LAST;
          end
          4'(SPCU_CMD_GSET): begin
            nxt_idx  = GEN_FIRST;
            nxt_last = GEN_LAST;
          end
          4'(SPCU_CMD_CSET): begin
            nxt_idx  = CNT_FIRST;
            nxt_last = CNT_LAST;
          end
          4'(SPCU_CMD_SSET): begin
            nxt_idx  = SER_FIRST;
            nxt_last = SER_LAST;
          end
          4'(SPCU_CMD_BACKUP): begin
            nxt_idx  = GEN_FIRST;
            nxt_last = SER_LAST;
            if (i_mem_wprot) begin
              nxt_rsp   = 4'(SPCU_RSP_WPROT);
              nxt_state = SPCU_FINISH;
            end else if (!sum_valid_ff) begin
              nxt_rsp   = 4'(SPCU_RSP_NOSUM);
              nxt_state = SPCU_FINISH;
            end
          end
          4'(SPCU_CMD_BKDIS): begin
            nxt_state    = SPCU_FINISH; // flag drops with the completion
          end
          default: begin
            nxt_rsp   = 4'(SPCU_RSP_UNDEF);
            nxt_state = SPCU_FINISH;
          end
        endcase
      end
      SPCU_WALK: begin
        case (op_ff)
          4'(SPCU_CMD_CLEAR): begin
            nxt_par[idx_ff] = 16'h0000;
          end
          4'(SPCU_CMD_BACKUP): begin
            nxt_bak[idx_ff] = cur_word;
          end
          default: begin
            nxt_act[idx_ff]  = sum_word;
            nxt_warn[idx_ff] = cur_bad;
          end
        endcase
        if (idx_ff == last_ff) begin
          nxt_state = SPCU_FINISH;
        end else begin
          nxt_idx = idx_ff + 5'h01;
        end
      end
      SPCU_FINISH: begin
        if (rsp_ff == 4'(SPCU_RSP_OK)) begin
          if (op_ff == 4'(SPCU_CMD_BACKUP)) begin
            nxt_bak_sum  = sum_out;
            nxt_bak_flag = 1'b1;
            nxt_sum_err  = 1'b0;
          end else if (op_ff == 4'(SPCU_CMD_CLEAR)) begin
            nxt_sum_valid = 1'b0;
          end else if (op_ff == 4'(SPCU_CMD_BKDIS)) begin
            nxt_bak_flag  = 1'b0;
          end else begin
            nxt_par_sum   = sum_out;
            nxt_sum_valid = 1'b1;
          end
        end
        // status and done bits written here; launch clears them
        nxt_cmd[STAT_LSB +: STAT_W] = rsp_ff;
        nxt_cmd[DONE_BIT]           = 1'b1;
        nxt_state                   = SPCU_IDLE;
      end
      default: begin
        nxt_state = SPCU_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff     <= SPCU_IDLE;
      cmd_ff       <= CMD_WORD_RST;
      op_ff        <= 4'h0;
      rsp_ff       <= 4'h0;
      idx_ff       <= 5'h00;
      last_ff      <= 5'h00;
      bak_flag_ff  <= 1'b0;
      sum_valid_ff <= 1'b0;
      sum_err_ff   <= 1'b0;
      warn_ff      <= '0;
      par_sum_ff   <= 16'h0000;
      bak_sum_ff   <= 16'h0000;
      force_d_ff   <= 1'b0;
      busy_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cmd_ff       <= nxt_cmd;
      op_ff        <= nxt_op;
      rsp_ff       <= nxt_rsp;
      idx_ff       <= nxt_idx;
      last_ff      <= nxt_last;
      bak_flag_ff  <= nxt_bak_flag;
      sum_valid_ff <= nxt_sum_valid;
      sum_err_ff   <= nxt_sum_err;
      warn_ff      <= nxt_warn;
      par_sum_ff   <= nxt_par_sum;
      bak_sum_ff   <= nxt_bak_sum;
      force_d_ff   <= i_force_exec;
      busy_ff      <= (nxt_state != SPCU_IDLE);
    end
  end

  // memory arrays, no reset so they map to storage
  always_ff @(posedge i_clk_sys) begin
    for (int k = 0; k < NWORDS; k++) begin
      par_ff[k] <= nxt_par[k];
      bak_ff[k] <= nxt_bak[k];
      act_ff[k] <= nxt_act[k];
    end
  end

  // outputs straight from flip-flops
  assign o_cmd_word    = cmd_ff;
  assign o_backup_flag = bak_flag_ff;
  assign o_sum_err     = sum_err_ff;
  assign o_warn        = warn_ff;
  assign o_busy        = busy_ff;
endmodule : spcu_unit
`default_nettype wire

// >>> bench/spcu_unit_props.sv
`timescale 1ns/1ps
`default_nettype none
// command word handshake checks seen from the unit's ports
module spcu_unit_props #(
  parameter int unsigned NWORDS = 30
) (
  input wire logic        i_clk_sys,     // clock
  input wire logic        i_rst_n,       // reset, active low
  input wire logic        i_periph_wr,   // data-change strobe
  input wire logic        i_prog_wr,     // program write
  input wire logic [15:0] i_wr_data,     // written word
  input wire logic        i_force_exec,  // execute force-set
  input wire logic        i_mem_wprot,   // memory write-protect
  input wire logic [15:0] o_cmd_word,    // command word
  input wire logic        o_backup_flag, // backup flag
  input wire logic        o_busy         // busy
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  // accepted request and finished command
  sequence s_take;
    i_periph_wr && i_force_exec && !i_prog_wr && !o_busy;
  endsequence
  sequence s_done;
    o_cmd_word[7] && !o_busy;
  endsequence
  a_start_clears: assert property (
    s_take |=> o_busy && o_cmd_word[7:0] == 8'h00 && o_cmd_word[11:8] == $past(i_wr_data[11:8]))
    else $error("start did not clear done and status");
  a_undef_status: assert property (
    s_take ##0 (i_wr_data[11:8] == 4'h0 || i_wr_data[11:8] > 4'h7) |-> ##3 (s_done ##0 o_cmd_word[3:0] == 4'h1))
    else $error("undefined code not reported");
  a_wprot_status: assert property (
    s_take ##0 (i_wr_data[11:8] == 4'h2 && i_mem_wprot) |-> ##3 (s_done ##0 o_cmd_word[3:0] == 4'h2))
    else $error("write protect not reported");
  a_walk_done: assert property (
    s_take ##0 i_wr_data[11:8] == 4'h1 |-> ##33 (s_done ##0 o_cmd_word[11:0] == 12'h180))
    else $error("full set did not end in time");
  a_serial_done: assert property (
    s_take ##0 i_wr_data[11:8] == 4'h7 |-> ##13 (s_done ##0 o_cmd_word[11:0] == 12'h780))
    else $error("serial subset did not end in time");
  a_idle_stable: assert property (
    !o_busy && !(i_periph_wr && i_force_exec && !i_prog_wr) |=> $stable(o_cmd_word[11:0]))
    else $error("command word changed while idle");
  a_exec_clear: assert property (
    (!i_force_exec && !o_busy) [*2] |=> !o_cmd_word[15])
    else $error("execute bit stayed on without force");
  a_backup_set: assert property (
    $rose(o_backup_flag) |-> $fell(o_busy) && o_cmd_word[11:0] == 12'h280)
    else $error("backup flag rose outside a backup");
  a_backup_drop: assert property (
    $fell(o_backup_flag) |-> $fell(o_busy) && o_cmd_word[11:0] == 12'h380)
    else $error("backup flag fell outside a disable");
endmodule : spcu_unit_props
bind spcu_unit spcu_unit_props #(.NWORDS(NWORDS)) u_props (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_periph_wr(i_periph_wr), .i_prog_wr(i_prog_wr),
  .i_wr_data(i_wr_data), .i_force_exec(i_force_exec), .i_mem_wprot(i_mem_wprot),
  .o_cmd_word(o_cmd_word), .o_backup_flag(o_backup_flag), .o_busy(o_busy)
);
`default_nettype wire

// >>> bench/spcu_periph.sv
`timescale 1ns/1ps
`default_nettype none
// programming device that force-sets the execute bit and writes codes
module spcu_periph (
  input  wire logic        i_clk_sys,    // clock
  output logic             o_periph_wr,  // data-change strobe
  output logic [15:0]      o_wr_data,    // written word
  output logic             o_force_exec  // execute force-set
);
  // idle at time zero
  initial begin
    o_periph_wr  = 1'b0;
    o_wr_data    = 16'h0000;
    o_force_exec = 1'b0;
  end
  // hold or release the force-set
  task automatic set_force(input logic v);
    @(posedge i_clk_sys);
    #1 o_force_exec = v;
  endtask : set_force
  // one write of a code; released lines stop showing the old value
  task automatic send_code(input logic [3:0] code);
    @(posedge i_clk_sys);
    #1 o_periph_wr = 1'b1;
    o_wr_data = {4'h0, code, 8'h00};
    @(posedge i_clk_sys);
    #1 o_periph_wr = 1'b0;
    o_wr_data = ~o_wr_data;
  endtask : send_code
endmodule : spcu_periph
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// command sequences against the system parameter command unit
module tb_top;
  import spcu_pkg::*;
  logic        clk, rst_n, prog_wr, wprot, par_we;
  logic [4:0]  par_addr;
  logic [15:0] par_wdata;
  wire         periph_wr, force_exec;
  wire  [15:0] wr_data;
  logic [15:0] cmd_word;
  logic        backup, sum_err, busy;
  logic [29:0] warn;
  logic [3:0]  undef_c [3] = '{4'h0, 4'h8, 4'hf};
  int          num_errors = 0;
  int          checked = 0;
  spcu_periph u_per (.i_clk_sys(clk), .o_periph_wr(periph_wr), .o_wr_data(wr_data), .o_force_exec(force_exec));
  spcu_unit #(.NWORDS(30)) u_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_periph_wr(periph_wr), .i_prog_wr(prog_wr),
    .i_wr_data(wr_data), .i_force_exec(force_exec), .i_mem_wprot(wprot), .i_par_we(par_we),
    .i_par_addr(par_addr), .i_par_wdata(par_wdata), .o_cmd_word(cmd_word), .o_backup_flag(backup),
    .o_sum_err(sum_err), .o_warn(warn), .o_busy(busy)
  );
  always #2.5 clk = ~clk;
  // compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // write one parameter word while idle
  task automatic par_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 par_we = 1'b1;
    par_addr = a;
    par_wdata = d;
    @(posedge clk);
    #1 par_we = 1'b0;
  endtask : par_wr
  // issue a code, wait for completion, check the word
  task automatic run(input logic [3:0] code, input logic [15:0] exp);
    int n;
    n = 0;
    u_per.send_code(code);
    @(posedge clk);
    #1;
    while (!(cmd_word[7] === 1'b1 && busy === 1'b0) && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk("cmd_word", cmd_word, exp);
  endtask : run
  // verdict
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // hang guard
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    final_report();
  end
  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    prog_wr = 1'b0;
    wprot = 1'b0;
    par_we = 1'b0;
    par_addr = 5'h00;
    par_wdata = 16'h0000;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("reset word", cmd_word, 16'h0000);
    chk("reset backup", backup, 1'b0);
    // parameter storage has no reset, so give every word a known value
    for (int w = 0; w < 30; w++) par_wr(5'(w), 16'h0000);
    par_wr(5'h00, 16'h1234);
    par_wr(5'h01, 16'h00a0);
    u_per.set_force(1'b1);
    run(4'h2, 16'h8283);
    for (int i = 0; i < 3; i++) run(undef_c[i], {4'h8, undef_c[i], 8'h81});
    run(4'h1, 16'h8180);
    chk("warn1", warn[1], 1'b1);
    chk("warn0", warn[0], 1'b0);
    wprot = 1'b1;
    run(4'h2, 16'h8282);
    chk("backup", backup, 1'b0);
    wprot = 1'b0;
    run(4'h2, 16'h8280);
    chk("backup", backup, 1'b1);
    prog_wr = 1'b1;
    run(4'h3, 16'h8280);
    prog_wr = 1'b0;
    chk("backup", backup, 1'b1);
    for (int c = 5; c < 8; c++) run(4'(c), {4'h8, 4'(c), 8'h80});
    chk("sum_err idle", sum_err, 1'b0);
    // subset sum now differs from the backup sum; a fresh force-set flags it
    u_per.set_force(1'b0);
    u_per.set_force(1'b1);
    @(posedge clk);
    #1 chk("sum_err", sum_err, 1'b1);
    run(4'h3, 16'h8380);
    chk("backup", backup, 1'b0);
    run(4'h4, 16'h8480);
    run(4'h2, 16'h8283);
    run(4'h1, 16'h8180);
    chk("warn", warn, 30'h0);
    u_per.set_force(1'b0);
    repeat (2) @(posedge clk);
    #1 chk("exec", cmd_word[15], 1'b0);
    run(4'h1, 16'h0180);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
